// ===== bench/tb_top.sv
// self-checking bench: both link ends face each other, one burst for each of modes 0 to 6, then a long mode 2 burst
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic start = 1'b0;
  logic enable = 1'b0;
  logic end_req = 1'b0;
  logic in_valid = 1'b0;
  logic out_ready = 1'b0;
  logic status_sel = 1'b0;
  logic took = 1'b0;
  logic pz = 1'b0;
  logic prev_rdy = 1'b1;
  logic [15:0] in_data = 16'h0000;
  logic [15:0] status_word = 16'h0000;
  logic [2:0] mode = 3'h0;
  logic in_ready, paused, s_done, r_done, out_valid, sd, rd;
  logic [15:0] s_crc, r_crc, sent_cnt, out_data, exp_crc, n_rx, w;
  logic [3:0] extra_words;
  logic [4:0] fill;
  int errors = 0;
  int check_count = 0;
  int stall = 5;
  logic [15:0] exp_q[$];
  urp_link_if urp_link_if_inst ();

  urp_snd urp_snd_inst (.clock(clock), .rst_b(rst_b), .ce(1'b1), .link(urp_link_if_inst.snd),
    .start(start), .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
    .status_sel(status_sel), .status_word(status_word), .paused(paused), .done(s_done),
    .crc(s_crc), .sent_cnt(sent_cnt));
  urp_rcv urp_rcv_inst (.clock(clock), .rst_b(rst_b), .ce(1'b1), .link(urp_link_if_inst.rcv),
    .enable(enable), .mode(mode), .end_req(end_req), .out_valid(out_valid),
    .out_data(out_data), .out_ready(out_ready), .extra_words(extra_words), .fill(fill),
    .crc(r_crc), .done(r_done));
  urp_link_props urp_link_props_inst (.clock(clock), .rst_b(rst_b),
    .strobe(urp_link_if_inst.strobe), .dd(urp_link_if_inst.dd),
    .dmardy_n(urp_link_if_inst.dmardy_n), .stop(urp_link_if_inst.stop));

  // clock generator
  always #10 clock = ~clock;

  // bench crc, msb first, kept apart from the design's helper
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d);
    for (int i = 15; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction

  // most late words a pause may bring, and the pause level that leaves room for them
  function automatic logic [4:0] max_ext(input logic [2:0] m);
    return (m >= 3'h3) ? 5'h03 : 5'h02;
  endfunction

  function automatic logic [4:0] near_lvl(input logic [2:0] m);
    return 5'h10 - max_ext(m) - 5'h03;
  endfunction

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    if (errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // one burst: stream, end mid-stream, drain, then compare totals
  task automatic burst(input logic [2:0] m, input int words);
    mode = m;
    stall = $urandom_range(9, 1);
    exp_crc = 16'h4ABA;
    n_rx = 16'h0000;
    sd = 1'b0;
    rd = 1'b0;
    pz = 1'b0;
    enable = 1'b1;
    start = 1'b1;
    for (int i = 0; i < 5000 && n_rx < words; i++) @(negedge clock);
    chk("burst words", 16'(n_rx >= 16'(words)), 16'h0001);
    end_req = 1'b1;
    for (int i = 0; i < 200 && !urp_link_if_inst.stop; i++) @(negedge clock);
    chk("stop raised", 16'(urp_link_if_inst.stop), 16'h0001);
    end_req = 1'b0;
    stall = 10;
    for (int i = 0; i < 200 && (fill != 5'h00 || out_valid); i++) @(negedge clock);
    chk("fifo drained", 16'(fill), 16'h0000);
    enable = 1'b0;
    start = 1'b0;
    for (int i = 0; i < 50 && !(sd && rd); i++) @(negedge clock);
    chk("done pulses", 16'({sd, rd}), 16'h0003);
    chk("sender crc", s_crc, exp_crc);
    chk("recipient crc", r_crc, exp_crc);
    chk("words sent", sent_cnt, n_rx);
    chk("paused seen", 16'(pz), 16'h0001);
  endtask

  // scoreboard at the sampling edge; pop before push keeps order strict
  always @(posedge clock) begin
    if (s_done) sd = 1'b1;
    if (r_done) rd = 1'b1;
    if (paused) pz = 1'b1;
    if (out_valid && out_ready) begin
      w = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hXXXX;
      chk("out data", out_data, w);
      exp_crc = crc_step(exp_crc, w);
      n_rx++;
    end
    took = in_valid && in_ready && rst_b;
    if (took) exp_q.push_back(in_data);
  end

  // stimulus off the sampling edge: valid gaps, stalls, status traffic
  always @(negedge clock) begin
    if (!in_valid || took) begin
      in_valid <= $urandom_range(3) != 0;
      in_data <= 16'($urandom);
    end
    out_ready <= $urandom_range(9) < stall;
    status_sel <= 1'($urandom_range(1));
    status_word <= 16'($urandom);
    prev_rdy <= urp_link_if_inst.dmardy_n;
    if (5'(extra_words) > max_ext(mode))
      chk("late words", 16'(extra_words), 16'(max_ext(mode)));
    if (fill >= 5'h10) chk("fill", 16'(fill), 16'h000F);
    if (prev_rdy && !urp_link_if_inst.dmardy_n && fill > 5'h04)
      chk("resume level", 16'(fill), 16'h0004);
    if (!prev_rdy && urp_link_if_inst.dmardy_n && enable && !end_req && fill < near_lvl(mode))
      chk("pause level", 16'(fill), 16'(near_lvl(mode)));
  end

  // main sequence; a one-word burst forces an end right after the first word
  initial begin
    void'($urandom(32'hA6C7));
    repeat (5) @(negedge clock);
    rst_b = 1'b1;
    chk("reset pins", 16'({urp_link_if_inst.strobe, urp_link_if_inst.dmardy_n,
      urp_link_if_inst.stop, in_ready, out_valid}), 16'h001A);
    chk("reset crc", r_crc, 16'h4ABA);
    for (int m = 0; m < 7; m++) burst(3'(m), (m == 0) ? 1 : $urandom_range(40, 8));
    burst(3'h2, 60);
    close_out();
  end

  // watchdog well beyond the longest expected run
  initial begin
    #1500us;
    errors++;
    close_out();
  end
endmodule

// ===== bench/urp_link_props.sv
// wire-level checker for the pause-aware burst link
module urp_link_props (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic strobe,
  input wire logic [15:0] dd,
  input wire logic dmardy_n,
  input wire logic stop
);
  logic [4:0] hi_cnt;
  logic [1:0] ext_cnt;
  logic first;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  // ready-high run length, late edges in a pause, first edge flag
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hi_cnt <= 5'h00;
      ext_cnt <= 2'h0;
      first <= 1'b1;
    end else begin
      hi_cnt <= (!dmardy_n) ? 5'h00 : hi_cnt + 5'(hi_cnt != 5'h1F);
      ext_cnt <= (!dmardy_n) ? 2'h0 : ext_cnt + 2'($changed(strobe) && ext_cnt != 2'h3);
      first <= first && !$changed(strobe);
    end
  end

  chk_strobe_halts: assert property ((dmardy_n && !stop)[*8] |=> $stable(strobe))
    else $error("strobe moved in pause");
  chk_late_edges: assert property (ext_cnt != 2'h3)
    else $error("too many late edges");
  chk_dd_hold: assert property ($changed(strobe) |=> $stable(dd))
    else $error("dd moved after edge");
  chk_edge_gap: assert property ($changed(strobe) |=> !$changed(strobe)[*2])
    else $error("edges too close");
  chk_rp_wait: assert property ($rose(stop) |-> hi_cnt >= 5'h0B)
    else $error("stop before wait");
  chk_stop_paused: assert property (stop |-> dmardy_n)
    else $error("stop while ready");
  chk_first_fall: assert property (first && $changed(strobe) |-> !strobe)
    else $error("first edge not a fall");
  chk_reset_idle: assert property ($rose(rst_b) |-> strobe && dmardy_n && !stop)
    else $error("link not idle after reset");

  cover property ($rose(dmardy_n) ##[1:4] $changed(strobe));
  cover property ($rose(stop));
  cover property ($fell(dmardy_n) && !stop);
endmodule

// ===== pkg/urp_link_if.sv
// link wires between the sending end and the receiving end
interface urp_link_if;
  logic strobe;
  logic [15:0] dd;
  logic dmardy_n;
  logic stop;

  modport snd (
    output strobe,
    output dd,
    input dmardy_n,
    input stop
  );

  modport rcv (
    input strobe,
    input dd,
    output dmardy_n,
    output stop
  );
endinterface

// ===== pkg/urp_pkg.sv
// shared constants, types and helpers for the pause-aware burst link
package urp_pkg;

  // clock and link timing
  localparam int CLK_MHZ = 50;
  localparam int T_RFS_NS = 75;
  localparam int T_RP_NS = 160;
  localparam int T_DVH_NS = 20;
  localparam int SYNC_CYC = 2;
  // least times round up to whole clock cycles
  localparam int T_RP_CYC = (T_RP_NS * CLK_MHZ + 999) / 1000;
  localparam int T_DVH_CYC = (T_DVH_NS * CLK_MHZ + 999) / 1000;
  // recipient waits tRP plus the sync delay on both directions of the cable
  localparam logic [4:0] RP_WAIT = 5'(T_RP_CYC + 2 * SYNC_CYC);
  localparam logic [1:0] DVH_WAIT = 2'(T_DVH_CYC);

  // sender word slot: data out at phase 0, strobe edge at DD_SETUP, slot ends at SLOT_LAST
  localparam logic [1:0] DD_SETUP = 2'h2;
  localparam logic [1:0] SLOT_LAST = 2'h3;

  // data and recipient fifo
  localparam int DW = 16;
  localparam int FIFO_AW = 4;
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam logic [4:0] PIPE_SLACK = 5'h3;
  localparam logic [4:0] FIFO_LO = 5'h4;
  localparam logic [4:0] EXTRA_SLOW = 5'h2;
  localparam logic [4:0] EXTRA_FAST = 5'h3;
  localparam logic [2:0] MODE_FAST_MIN = 3'h3;

  // crc
  localparam logic [15:0] CRC_INIT = 16'h4ABA;
  localparam logic [15:0] CRC_POLY = 16'h1021;

  // gray coded along idle -> run -> pause -> done
  typedef enum logic [1:0] {
    URP_S_IDLE = 2'h0,
    URP_S_RUN = 2'h1,
    URP_S_PAUSE = 2'h3,
    URP_S_DONE = 2'h2
  } urp_snd_state_t;

  typedef enum logic [1:0] {
    URP_R_IDLE = 2'h0,
    URP_R_XFER = 2'h1,
    URP_R_WAIT = 2'h3,
    URP_R_STOP = 2'h2
  } urp_rcv_state_t;

  // most late words a pause may bring for the given mode
  function automatic logic [4:0] urp_max_extra(input logic [2:0] mode);
    urp_max_extra = (mode >= MODE_FAST_MIN) ? EXTRA_FAST : EXTRA_SLOW;
  endfunction

  // fill level that triggers a pause, leaving room for late words and input pipeline
  function automatic logic [4:0] urp_near_full(input logic [2:0] mode);
    urp_near_full = FIFO_DEPTH - urp_max_extra(mode) - PIPE_SLACK;
  endfunction

  // one word into the crc, msb first
  function automatic logic [15:0] urp_crc_next(input logic [15:0] crc, input logic [15:0] d);
    logic [15:0] c;
    logic fb;
    c = crc;
    fb = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      fb = c[15] ^ d[i];
      c = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    end
    urp_crc_next = c;
  endfunction

endpackage

// ===== rtl/urp_rcv.sv
// receiving end: strobe capture, fifo with hysteresis, pause and termination timing
// Notes on behaviour
// - recipient pauses by negating ready, any time
// - pause for near-full fifo or ending
// - no least negation time, reassert freely
// - sender may delay edge after quick reassert
// - hysteresis between pause and resume levels
// - take two late words slow, three fast
// - sender stops strobing within tRFS
// - sender synchronises incoming ready signal
// - word counts only after a strobe edge
// - unstrobed word must be restorable after end
// - pending word survives other bus traffic
// - trigger depth covers all loop delays
// - keep capturing edges up to tRP
// - late words do not mean sender paused
// - wait tRP before terminating the burst
// - sender may settle clocks after last edge
// - any count of late words, any boundary
// - sender paused after data hold time
// - unstrobed words stay out of crc
module urp_rcv (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  urp_link_if.rcv link,
  input wire logic enable,
  input wire logic [2:0] mode,
  input wire logic end_req,
  output logic out_valid,
  output logic [15:0] out_data,
  input wire logic out_ready,
  output logic [3:0] extra_words,
  output logic [4:0] fill,
  output logic [15:0] crc,
  output logic done
);

  typedef struct packed {
    urp_pkg::urp_rcv_state_t st;
    logic stb_s1;
    logic stb_s2;
    logic stb_s3;
    logic [15:0] dd_s1;
    logic [15:0] dd_s2;
    logic [15:0][15:0] mem;
    logic [3:0] wp;
    logic [3:0] rp;
    logic [4:0] cnt;
    logic full_hold;
    logic dmardy_n;
    logic stop;
    logic [4:0] timer;
    logic [3:0] extra;
    logic [15:0] crc;
    logic out_valid;
    logic [15:0] out_data;
    logic done;
  } urp_rcv_st_t;

  // the fifo words sit in the state struct too, so the whole recipient
  // freezes with ce and leaves reset from one place
  urp_rcv_st_t r;
  urp_rcv_st_t next_r;

  // next state
  always_comb begin
    logic edge_seen;
    logic take;
    logic give;
    logic [4:0] level_hi;
    edge_seen = 1'b0;
    take = 1'b0;
    give = 1'b0;
    level_hi = 5'h00;
    next_r = r;
    next_r.done = 1'b0;

    // strobe and data both cross two flops before use
    // dd is held two clocks around each edge, so dd_s2 is settled when the
    // delayed edge shows; a recipient frozen by ce for a whole word slot
    // can miss an edge, so ce must not stop it during a burst
    next_r.stb_s1 = link.strobe;
    next_r.stb_s2 = r.stb_s1;
    next_r.stb_s3 = r.stb_s2;
    next_r.dd_s1 = link.dd;
    next_r.dd_s2 = r.dd_s1;
    edge_seen = r.stb_s2 ^ r.stb_s3;

    // capture in every active state, including the tRP wait
    take = edge_seen && (r.st != urp_pkg::URP_R_IDLE) && (r.cnt != urp_pkg::FIFO_DEPTH);
    if (take) begin
      next_r.mem[r.wp] = r.dd_s2;
      next_r.wp = r.wp + 4'h1;
      // only strobed words feed the crc
      next_r.crc = urp_pkg::urp_crc_next(r.crc, r.dd_s2);
    end

    // the recipient never ends a burst on this count, only on its own timer
    // late words are only counted for status; any count is fine
    if (take && r.dmardy_n && (r.extra != 4'hF)) begin
      next_r.extra = r.extra + 4'h1;
    end

    // a word moves on whenever the output flop is empty or being taken,
    // which gives one word of slack on the user side
    // output stage keeps out_data on a flop
    if ((!r.out_valid || out_ready) && (r.cnt != 5'h00)) begin
      give = 1'b1;
      next_r.out_data = r.mem[r.rp];
      next_r.out_valid = 1'b1;
      next_r.rp = r.rp + 4'h1;
    end else if (out_ready) begin
      next_r.out_valid = 1'b0;
    end

    case ({take, give})
      2'b10: next_r.cnt = r.cnt + 5'h01;
      2'b01: next_r.cnt = r.cnt - 5'h01;
      default: next_r.cnt = r.cnt;
    endcase

    // loop budget: one clock to register ready, two sync clocks and one
    // strobe flop at the sender, three strobe stages here; with 4-clock
    // word slots only a couple of late words arrive, and the reserve above
    // the trigger covers the mode maximum plus that pipeline slack
    // trigger leaves room for the mode's late words plus sync and edge stages
    level_hi = urp_pkg::urp_near_full(mode);
    // separate pause and resume levels avoid a pause every word or two
    if (next_r.cnt >= level_hi) begin
      next_r.full_hold = 1'b1;
    end else if (next_r.cnt <= urp_pkg::FIFO_LO) begin
      next_r.full_hold = 1'b0;
    end

    case (r.st)
      urp_pkg::URP_R_IDLE: begin
        // idle keeps ready negated and stop low, so the sender sees a paused link
        next_r.dmardy_n = 1'b1;
        next_r.stop = 1'b0;
        if (enable) begin
          next_r.st = urp_pkg::URP_R_XFER;
          next_r.crc = urp_pkg::CRC_INIT;
          next_r.extra = 4'h0;
        end
      end
      urp_pkg::URP_R_XFER: begin
        if (end_req || !enable) begin
          // ending wins over a resume, so no new word is asked for
          // negate ready before ending, then wait out tRP
          next_r.st = urp_pkg::URP_R_WAIT;
          next_r.dmardy_n = 1'b1;
          next_r.timer = 5'h00;
        end else begin
          // pause on near-full, resume once the fill falls to FIFO_LO
          next_r.dmardy_n = next_r.full_hold;
        end
        // a new pause starts a new count of late words
        if (!r.dmardy_n && next_r.dmardy_n) begin
          next_r.extra = 4'h0;
        end
      end
      urp_pkg::URP_R_WAIT: begin
        // time only, never the count of late words, says the sender has stopped
        // the wait is tRP in clocks plus both sync paths; words that land
        // during it are still captured by the fifo logic above
        if (r.timer != urp_pkg::RP_WAIT) begin
          next_r.timer = r.timer + 5'h01;
        end else begin
          next_r.st = urp_pkg::URP_R_STOP;
          next_r.stop = 1'b1;
        end
      end
      default: begin
        // stop stays up until the user drops enable
        // dropping enable is the user's acknowledgement of the finished burst
        if (!enable) begin
          next_r.st = urp_pkg::URP_R_IDLE;
          next_r.stop = 1'b0;
          next_r.done = 1'b1;
        end
      end
    endcase
  end

  // state register
  // reset matches the idle pins: strobe seen high, ready negated
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      r <= '{st: urp_pkg::URP_R_IDLE, stb_s1: 1'b1, stb_s2: 1'b1, stb_s3: 1'b1,
             dmardy_n: 1'b1, crc: urp_pkg::CRC_INIT, default: '0};
    end else if (ce) begin
      r <= next_r;
    end
  end

  // ports straight from the state register
  // stop is a level and done a single pulse, both from flops, so the
  // user side never sees a glitch while the state changes
  assign link.dmardy_n = r.dmardy_n;
  assign link.stop = r.stop;
  assign out_valid = r.out_valid;
  assign out_data = r.out_data;
  assign extra_words = r.extra;
  assign fill = r.cnt;
  assign crc = r.crc;
  assign done = r.done;

endmodule

// ===== rtl/urp_snd.sv
// sending end: two-entry word buffer, strobe generation and pause handling
module urp_snd (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  urp_link_if.snd link,
  input wire logic start,
  input wire logic in_valid,
  input wire logic [15:0] in_data,
  output logic in_ready,
  input wire logic status_sel,
  input wire logic [15:0] status_word,
  output logic paused,
  output logic done,
  output logic [15:0] crc,
  output logic [15:0] sent_cnt
);

  typedef struct packed {
    urp_pkg::urp_snd_state_t st;
    logic [1:0][15:0] buf_w;
    logic [1:0] cnt;
    logic in_ready;
    logic [1:0] phase;
    logic strobe;
    logic [15:0] dd;
    logic rdy_s1;
    logic rdy_s2;
    logic stop_s1;
    logic stop_s2;
    logic [1:0] hold;
    logic paused;
    logic done;
    logic [15:0] crc;
    logic [15:0] sent_cnt;
  } urp_snd_st_t;

  urp_snd_st_t r;
  urp_snd_st_t next_r;

  // next state
  always_comb begin
    logic pop;
    logic push;
    logic [1:0] cnt_pop;
    pop = 1'b0;
    push = 1'b0;
    cnt_pop = 2'h0;
    next_r = r;
    next_r.rdy_s1 = link.dmardy_n;
    next_r.rdy_s2 = r.rdy_s1;
    next_r.stop_s1 = link.stop;
    next_r.stop_s2 = r.stop_s1;
    next_r.done = 1'b0;
    case (r.st)
      urp_pkg::URP_S_IDLE: begin
        next_r.phase = 2'h0;
        if (start) begin
          next_r.st = urp_pkg::URP_S_RUN;
          next_r.crc = urp_pkg::CRC_INIT;
          next_r.sent_cnt = 16'h0000;
        end
      end
      urp_pkg::URP_S_RUN: begin
        if (r.stop_s2) begin
          // unstrobed word stays in the buffer, nothing to rewind
          next_r.st = urp_pkg::URP_S_DONE;
        end else if (r.rdy_s2) begin
          // stop at once, no counting of late words; 2 sync + 1 clocks stay inside tRFS
          next_r.st = urp_pkg::URP_S_PAUSE;
          next_r.hold = 2'h0;
        end else if (r.cnt != 2'h0) begin
          if (r.phase == 2'h0) begin
            next_r.dd = r.buf_w[0];
          end
          if (r.phase == urp_pkg::DD_SETUP) begin
            // only a strobe edge makes the word delivered
            next_r.strobe = ~r.strobe;
            pop = 1'b1;
            next_r.crc = urp_pkg::urp_crc_next(r.crc, r.dd);
            next_r.sent_cnt = r.sent_cnt + 16'h0001;
          end
          next_r.phase = (r.phase == urp_pkg::SLOT_LAST) ? 2'h0 : r.phase + 2'h1;
        end else begin
          next_r.phase = 2'h0;
        end
      end
      urp_pkg::URP_S_PAUSE: begin
        // settle a few clocks after the last edge before calling it paused
        if (r.hold != urp_pkg::DVH_WAIT) begin
          next_r.hold = r.hold + 2'h1;
        end else begin
          next_r.paused = 1'b1;
        end
        // other bus traffic may use dd; the pending word is reloaded from the buffer
        if (r.paused && status_sel) begin
          next_r.dd = status_word;
        end
        if (r.stop_s2) begin
          next_r.st = urp_pkg::URP_S_DONE;
          next_r.paused = 1'b0;
        end else if (!r.rdy_s2) begin
          // restart the slot, so a quick re-ready delays the next edge
          next_r.st = urp_pkg::URP_S_RUN;
          next_r.phase = 2'h0;
          next_r.paused = 1'b0;
        end
      end
      default: begin
        if (!r.stop_s2 && !start) begin
          next_r.st = urp_pkg::URP_S_IDLE;
          next_r.done = 1'b1;
        end
      end
    endcase
    // buffer: pop at strobe, push from user
    push = in_valid && r.in_ready;
    if (pop) begin
      next_r.buf_w[0] = r.buf_w[1];
    end
    cnt_pop = pop ? r.cnt - 2'h1 : r.cnt;
    if (push) begin
      next_r.buf_w[cnt_pop[0]] = in_data;
    end
    next_r.cnt = push ? cnt_pop + 2'h1 : cnt_pop;
    next_r.in_ready = (next_r.cnt != 2'h2);
  end

  // state register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      r <= '{st: urp_pkg::URP_S_IDLE, strobe: 1'b1, rdy_s1: 1'b1, rdy_s2: 1'b1,
             in_ready: 1'b1, crc: urp_pkg::CRC_INIT, default: '0};
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign link.strobe = r.strobe;
  assign link.dd = r.dd;
  assign in_ready = r.in_ready;
  assign paused = r.paused;
  assign done = r.done;
  assign crc = r.crc;
  assign sent_cnt = r.sent_cnt;

endmodule
